// ==== aofc_pkg.sv ====
package aofc_pkg;

    // ---------------------------------------------------------------
    // register indices (byte address = index * 4)
    // ---------------------------------------------------------------
    localparam logic [11:0] IDX_SEL_HI   = 12'h559;
    localparam logic [11:0] IDX_SEL_LO   = 12'h55A;
    localparam logic [11:0] IDX_FORMAT   = 12'h561;
    localparam logic [11:0] IDX_OR_CLR   = 12'h562;
    localparam logic [11:0] IDX_OR_STAT  = 12'h563;
    localparam logic [11:0] IDX_CH_ORDER = 12'h564;
    localparam logic [11:0] IDX_LANE     = 12'h56E;

    // ---------------------------------------------------------------
    // reset values
    // ---------------------------------------------------------------
    localparam logic [7:0] RST_SEL_HI   = 8'h00;
    localparam logic [7:0] RST_SEL_LO   = 8'h01;
    localparam logic [7:0] RST_FORMAT   = 8'h01;
    localparam logic [7:0] RST_OR_CLR   = 8'h00;
    localparam logic [7:0] RST_CH_ORDER = 8'h00;
    localparam logic [7:0] RST_LANE     = 8'h10;

    // ---------------------------------------------------------------
    // writable bit masks (others read as zero)
    // ---------------------------------------------------------------
    localparam logic [7:0] MSK_SEL_HI   = 8'h77;
    localparam logic [7:0] MSK_SEL_LO   = 8'h07;
    localparam logic [7:0] MSK_FORMAT   = 8'h07;
    localparam logic [7:0] MSK_CH_ORDER = 8'h01;
    localparam logic [7:0] MSK_LANE     = 8'h10;

    // ---------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------
    localparam int CB2_LSB    = 0;
    localparam int CB1_LSB    = 4;
    localparam int CB0_LSB    = 0;
    localparam int FMT_LSB    = 0;
    localparam int INVERT_BIT = 2;
    localparam int SWAP_BIT   = 0;
    localparam int LANE_LOW_BIT = 4;

    localparam logic [1:0] FMT_OFFSET_BIN = 2'h0;
    localparam logic [1:0] CS_ONE         = 2'h1;
    localparam logic [1:0] CS_TWO         = 2'h2;
    localparam logic [1:0] CS_THREE       = 2'h3;

    // ---------------------------------------------------------------
    // control bit sources
    // ---------------------------------------------------------------
    typedef enum logic [2:0]
    {
        AOFC_SRC_ZERO  = 3'b000,
        AOFC_SRC_OVR   = 3'b001,
        AOFC_SRC_VDR0  = 3'b010,
        AOFC_SRC_VDR1  = 3'b011,
        AOFC_SRC_VDRHL = 3'b100
    } aofc_src_t;

endpackage

// ==== aofc_ovr_track.sv ====
`timescale 1ns/1ps
// sticky overrange status per virtual converter with hold-off clear
module aofc_ovr_track
#(
    parameter int NUM_CONV = 8
)
(
    // clock and reset
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    // events and control
    input  wire logic [NUM_CONV-1:0] ovr_event_i,
    input  wire logic [NUM_CONV-1:0] clear_i,
    // status
    output logic      [NUM_CONV-1:0] status_o
);

    logic [NUM_CONV-1:0] status_ff;

    genvar g;
    generate
        for (g = 0; g < NUM_CONV; g++)
        begin : g_conv
            // clear holds the bit off while set; events otherwise stick
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                    status_ff[g] <= 1'b0;
                else if (clear_i[g])
                    status_ff[g] <= 1'b0;
                else if (ovr_event_i[g])
                    status_ff[g] <= 1'b1;
            end

            clear_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
                clear_i[g] |=> !status_ff[g])
                else $error("overrange bit not held off by clear");

            // an unmasked event followed by two cycles without clear
            sequence ev_then_quiet;
                (ovr_event_i[g] && !clear_i[g]) ##1 !clear_i[g] [*2];
            endsequence

            sticky_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
                ev_then_quiet |-> status_ff[g])
                else $error("overrange bit did not stick");
        end
    endgenerate

    assign status_o = status_ff;

endmodule

// ==== aofc_regs.sv ====
`timescale 1ns/1ps
module aofc_regs
#(
    parameter int DW       = 16,
    parameter int NUM_CONV = 8
)
(
    // clock and reset
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    // wishbone slave
    input  wire logic                cyc_i,
    input  wire logic                stb_i,
    input  wire logic                we_i,
    input  wire logic [13:0]         adr_i,
    input  wire logic [3:0]          sel_i,
    input  wire logic [31:0]         dat_i,
    output logic      [31:0]         dat_o,
    output logic                     ack_o,
    // converter side
    input  wire logic [DW-1:0]       sample_a_i,
    input  wire logic [DW-1:0]       sample_b_i,
    input  wire logic [1:0]          ctrl_bits_num_i,
    input  wire logic                ovr_flag_i,
    input  wire logic                vdr_bit0_i,
    input  wire logic                vdr_bit1_i,
    input  wire logic                vdr_hilo_i,
    input  wire logic [NUM_CONV-1:0] ovr_event_i,
    // formatted output
    output logic      [DW-1:0]       out_a_o,
    output logic      [DW-1:0]       out_b_o,
    output logic      [2:0]          ctrl_bits_o,
    output logic                     lane_rate_low_o
);

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    logic [7:0]          sel_hi_ff;
    logic [7:0]          sel_lo_ff;
    logic [7:0]          format_ff;
    logic [7:0]          or_clr_ff;
    logic [7:0]          ch_order_ff;
    logic [7:0]          lane_ff;
    logic                ack_ff;
    logic [31:0]         dat_ff;
    logic [NUM_CONV-1:0] or_status;
    logic [DW-1:0]       out_a_ff;
    logic [DW-1:0]       out_b_ff;
    logic [2:0]          ctrl_ff;
    logic [11:0]         idx;
    logic                wr_en;
    logic                rd_en;

    assign idx   = adr_i[13:2];
    assign wr_en = cyc_i && stb_i && we_i && !ack_ff && sel_i[0];
    assign rd_en = cyc_i && stb_i && !we_i && !ack_ff;

    // merge a byte into a register under its writable mask
    function automatic logic [7:0] wmask(input logic [7:0] mask, input logic [7:0] d);
        wmask = d & mask;
    endfunction

    // pick a control bit source from a selector code
    function automatic logic pick_src(input logic [2:0] code, input logic ovr, input logic v0,
                                      input logic v1, input logic hl);
        pick_src = 1'b0;
        case (code)
            aofc_pkg::AOFC_SRC_OVR:   pick_src = ovr;
            aofc_pkg::AOFC_SRC_VDR0:  pick_src = v0;
            aofc_pkg::AOFC_SRC_VDR1:  pick_src = v1;
            aofc_pkg::AOFC_SRC_VDRHL: pick_src = hl;
            default:                  pick_src = 1'b0;
        endcase
    endfunction

    // ---------------------------------------------------------------
    // register writes
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sel_hi_ff   <= aofc_pkg::RST_SEL_HI;
            sel_lo_ff   <= aofc_pkg::RST_SEL_LO;
            format_ff   <= aofc_pkg::RST_FORMAT;
            or_clr_ff   <= aofc_pkg::RST_OR_CLR;
            ch_order_ff <= aofc_pkg::RST_CH_ORDER;
            lane_ff     <= aofc_pkg::RST_LANE;
        end
        else if (wr_en)
        begin
            case (idx)
                aofc_pkg::IDX_SEL_HI:   sel_hi_ff   <= wmask(aofc_pkg::MSK_SEL_HI, dat_i[7:0]);
                aofc_pkg::IDX_SEL_LO:   sel_lo_ff   <= wmask(aofc_pkg::MSK_SEL_LO, dat_i[7:0]);
                aofc_pkg::IDX_FORMAT:   format_ff   <= wmask(aofc_pkg::MSK_FORMAT, dat_i[7:0]);
                aofc_pkg::IDX_OR_CLR:   or_clr_ff   <= dat_i[7:0];
                aofc_pkg::IDX_CH_ORDER: ch_order_ff <= wmask(aofc_pkg::MSK_CH_ORDER, dat_i[7:0]);
                aofc_pkg::IDX_LANE:     lane_ff     <= wmask(aofc_pkg::MSK_LANE, dat_i[7:0]);
                default:                ;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // bus answer: one ack a cycle after the strobe, read data registered
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_ff <= 1'b0;
        else
            ack_ff <= cyc_i && stb_i && !ack_ff;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            dat_ff <= 32'h0000_0000;
        else if (rd_en)
        begin
            case (idx)
                aofc_pkg::IDX_SEL_HI:   dat_ff <= {24'h00_0000, sel_hi_ff};
                aofc_pkg::IDX_SEL_LO:   dat_ff <= {24'h00_0000, sel_lo_ff};
                aofc_pkg::IDX_FORMAT:   dat_ff <= {24'h00_0000, format_ff};
                aofc_pkg::IDX_OR_CLR:   dat_ff <= {24'h00_0000, or_clr_ff};
                aofc_pkg::IDX_OR_STAT:  dat_ff <= {24'h00_0000, or_status[7:0]};
                aofc_pkg::IDX_CH_ORDER: dat_ff <= {24'h00_0000, ch_order_ff};
                aofc_pkg::IDX_LANE:     dat_ff <= {24'h00_0000, lane_ff};
                default:                dat_ff <= 32'h0000_0000;
            endcase
        end
    end

    assign ack_o = ack_ff;
    assign dat_o = dat_ff;

    // ---------------------------------------------------------------
    // overrange tracking
    // ---------------------------------------------------------------
    aofc_ovr_track #(.NUM_CONV(NUM_CONV)) u_ovr
    (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .ovr_event_i (ovr_event_i),
        .clear_i     (or_clr_ff[NUM_CONV-1:0]),
        .status_o    (or_status)
    );

    // ---------------------------------------------------------------
    // sample shaping: swap, invert, format
    // ---------------------------------------------------------------
    function automatic logic [DW-1:0] shape(input logic [DW-1:0] s, input logic inv, input logic [1:0] fmt);
        logic [DW-1:0] t;
        t = inv ? ~s : s;
        if (fmt == aofc_pkg::FMT_OFFSET_BIN)
            t[DW-1] = ~t[DW-1];
        shape = t;
    endfunction

    logic       swap;
    logic       inv;
    logic [1:0] fmt;
    assign swap = ch_order_ff[aofc_pkg::SWAP_BIT];
    assign inv  = format_ff[aofc_pkg::INVERT_BIT];
    assign fmt  = format_ff[aofc_pkg::FMT_LSB +: 2];

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            out_a_ff <= '0;
            out_b_ff <= '0;
        end
        else
        begin
            out_a_ff <= shape(swap ? sample_b_i : sample_a_i, inv, fmt);
            out_b_ff <= shape(swap ? sample_a_i : sample_b_i, inv, fmt);
        end
    end

    // ---------------------------------------------------------------
    // control bits
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ctrl_ff <= 3'h0;
        else
        begin
            ctrl_ff[2] <= (ctrl_bits_num_i == aofc_pkg::CS_THREE) &&
                pick_src(sel_hi_ff[aofc_pkg::CB2_LSB +: 3], ovr_flag_i, vdr_bit0_i, vdr_bit1_i, vdr_hilo_i);
            ctrl_ff[1] <= (ctrl_bits_num_i >= aofc_pkg::CS_TWO) &&
                pick_src(sel_hi_ff[aofc_pkg::CB1_LSB +: 3], ovr_flag_i, vdr_bit0_i, vdr_bit1_i, vdr_hilo_i);
            ctrl_ff[0] <= (ctrl_bits_num_i >= aofc_pkg::CS_ONE) &&
                pick_src(sel_lo_ff[aofc_pkg::CB0_LSB +: 3], ovr_flag_i, vdr_bit0_i, vdr_bit1_i, vdr_hilo_i);
        end
    end

    assign out_a_o         = out_a_ff;
    assign out_b_o         = out_b_ff;
    assign ctrl_bits_o     = ctrl_ff;
    assign lane_rate_low_o = lane_ff[aofc_pkg::LANE_LOW_BIT];

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    cb2_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ctrl_bits_num_i != aofc_pkg::CS_THREE |=> !ctrl_ff[2])
        else $error("control bit 2 set without three control bits");

    cb2_ovr_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ctrl_bits_num_i == aofc_pkg::CS_THREE && sel_hi_ff[2:0] == 3'h1) |=> ctrl_ff[2] == $past(ovr_flag_i))
        else $error("control bit 2 not following overrange");

    cb1_sel_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ctrl_bits_num_i >= aofc_pkg::CS_TWO && sel_hi_ff[6:4] == 3'h3) |=> ctrl_ff[1] == $past(vdr_bit1_i))
        else $error("control bit 1 not following its selector");

    cb0_sel_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ctrl_bits_num_i != 2'h0 && sel_lo_ff[2:0] == 3'h4) |=> ctrl_ff[0] == $past(vdr_hilo_i))
        else $error("control bit 0 not following its selector");

    swap_order_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ch_order_ff[0] && format_ff[2:0] == 3'h1) |=> out_a_ff == $past(sample_b_i))
        else $error("channel swap not applied");

    invert_fmt_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (!ch_order_ff[0] && format_ff[2:0] == 3'h5) |=> out_a_ff == ~$past(sample_a_i))
        else $error("sample invert not applied");

    offset_bin_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (!ch_order_ff[0] && format_ff[2:0] == 3'h0) |=>
            out_b_ff == {~$past(sample_b_i[DW-1]), $past(sample_b_i[DW-2:0])})
        else $error("offset binary conversion wrong");

    status_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (rd_en && idx == aofc_pkg::IDX_OR_STAT) |=> ack_ff && dat_ff[7:0] == $past(or_status[7:0]))
        else $error("overrange status read mismatch");

endmodule

// ==== aofc_regs_tb.sv ====
`timescale 1ns/1ps
module aofc_regs_tb;
    // ---------------------------------------------------------------
    // signals
    // ---------------------------------------------------------------
    typedef struct packed {logic [11:0] idx; logic [7:0] wd; logic [7:0] rd;} aofc_row_t;
    logic        clk_i;
    logic        rst_i;
    logic        cyc_i;
    logic        stb_i;
    logic        we_i;
    logic [13:0] adr_i;
    logic [3:0]  sel_i;
    logic [31:0] dat_i;
    logic [31:0] dat_o;
    logic        ack_o;
    logic [15:0] sample_a_i;
    logic [15:0] sample_b_i;
    logic [1:0]  ctrl_bits_num_i;
    logic [3:0]  flg;
    logic [7:0]  ovr_event_i;
    logic [15:0] out_a_o;
    logic [15:0] out_b_o;
    logic [2:0]  ctrl_bits_o;
    logic        lane_rate_low_o;
    logic [31:0] q;
    logic [2:0]  c;
    logic [2:0]  e;
    int          n_mismatch;
    int          checks;
    // last six rows write the reset values back
    aofc_row_t   rows [14] = '{'{12'h559, 8'hFF, 8'h77}, '{12'h55A, 8'hFF, 8'h07}, '{12'h561, 8'hFF, 8'h07},
                               '{12'h562, 8'hFF, 8'hFF}, '{12'h563, 8'hFF, 8'h00}, '{12'h564, 8'hFF, 8'h01},
                               '{12'h56E, 8'h00, 8'h00}, '{12'h560, 8'hFF, 8'h00}, '{12'h559, 8'h00, 8'h00},
                               '{12'h55A, 8'h01, 8'h01}, '{12'h561, 8'h01, 8'h01}, '{12'h562, 8'h00, 8'h00},
                               '{12'h564, 8'h00, 8'h00}, '{12'h56E, 8'h10, 8'h10}};

    aofc_regs u_aofc_regs
    (
        .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
        .sample_a_i, .sample_b_i, .ctrl_bits_num_i, .ovr_event_i,
        .ovr_flag_i(flg[0]), .vdr_bit0_i(flg[1]), .vdr_bit1_i(flg[2]), .vdr_hilo_i(flg[3]),
        .out_a_o, .out_b_o, .ctrl_bits_o, .lane_rate_low_o
    );

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    initial
    begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wb(input logic w, input logic [11:0] idx, input logic [7:0] d, input logic [3:0] s = 4'hF);
        int n;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= {idx, 2'b00};
        sel_i <= s;
        dat_i <= {24'h0, d};
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack_o !== 1'b1 && n < 50);
        if (n >= 50)
        begin
            chk(32'h0, 32'h1);
            report_and_stop;
        end
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] idx, input logic [7:0] exp);
        wb(1'b0, idx, 8'h00);
        chk(q, {24'h0, exp});
    endtask

    task automatic settle;
        repeat (3) @(posedge clk_i);
        #1;
    endtask

    task automatic pulse(input logic [7:0] v);
        @(posedge clk_i);
        ovr_event_i <= v;
        @(posedge clk_i);
        ovr_event_i <= 8'h00;
    endtask

    // sample shaping: invert first, then offset binary flips the sign bit
    function automatic logic [15:0] shp(input logic [15:0] x, input logic [2:0] f);
        shp = f[2] ? ~x : x;
        if (f[1:0] == 2'b00)
            shp[15] = ~shp[15];
    endfunction

    function automatic logic src(input logic [2:0] code, input logic [3:0] p);
        src = (code >= 3'd1 && code <= 3'd4) ? p[code - 3'd1] : 1'b0;
    endfunction

    task automatic report_and_stop;
        $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clk_i);
        n_mismatch++;
        report_and_stop;
    end

    // ---------------------------------------------------------------
    // tests
    // ---------------------------------------------------------------
    initial
    begin
        {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} = '0;
        {sample_a_i, sample_b_i, ctrl_bits_num_i, flg, ovr_event_i} = '0;
        rst_i = 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (rows[i])
        begin
            wb(1'b1, rows[i].idx, rows[i].wd);
            rd(rows[i].idx, rows[i].rd);
        end
        $display("done: register table");
        wb(1'b1, 12'h564, 8'h01, 4'hE);
        rd(12'h564, 8'h00);
        wb(1'b1, 12'h561, 8'h04);
        wb(1'b1, 12'h56E, 8'h00);
        settle;
        chk(lane_rate_low_o, 1'b0);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 8; i < 14; i++)
            rd(rows[i].idx, rows[i].rd);
        rd(12'h563, 8'h00);
        chk(lane_rate_low_o, 1'b1);
        $display("done: reset values");
        @(posedge clk_i);
        sample_a_i <= 16'h1234;
        sample_b_i <= 16'h8001;
        for (int k = 0; k < 16; k++)
        begin
            wb(1'b1, 12'h561, {5'h0, k[2:0]});
            wb(1'b1, 12'h564, {7'h0, k[3]});
            settle;
            chk(out_a_o, shp(k[3] ? 16'h8001 : 16'h1234, k[2:0]));
            chk(out_b_o, shp(k[3] ? 16'h1234 : 16'h8001, k[2:0]));
        end
        $display("done: data path");
        for (int k = 0; k < 8; k++)
        begin
            c = k[2:0];
            wb(1'b1, 12'h559, {1'b0, c, 1'b0, c + 3'd1});
            wb(1'b1, 12'h55A, {5'h0, c + 3'd2});
            for (int j = 0; j < 64; j++)
            begin
                @(posedge clk_i);
                flg <= j[3:0];
                ctrl_bits_num_i <= j[5:4];
                settle;
                e[2] = (j[5:4] == 2'd3) ? src(c + 3'd1, j[3:0]) : 1'b0;
                e[1] = (j[5:4] >= 2'd2) ? src(c, j[3:0]) : 1'b0;
                e[0] = (j[5:4] >= 2'd1) ? src(c + 3'd2, j[3:0]) : 1'b0;
                chk(ctrl_bits_o, e);
            end
        end
        $display("done: control bits");
        pulse(8'h08);
        settle;
        rd(12'h563, 8'h08);
        wb(1'b1, 12'h562, 8'h08);
        rd(12'h563, 8'h00);
        pulse(8'h89);
        settle;
        rd(12'h563, 8'h81);
        wb(1'b1, 12'h562, 8'h00);
        pulse(8'h08);
        settle;
        rd(12'h563, 8'h89);
        $display("done: overrange");
        report_and_stop;
    end
endmodule
